/* File: hw/sdac_pkg.sv */
/*
 * Package of the serial DAC control block: frame layout, command codes,
 * reset codes and the packed carriers shared by the design files.
 * Assumes nothing of its surroundings.
 */
package sdac_pkg;

    // Shift register and frame layout
    localparam int SHIFT_W = 32;
    localparam int WORD_W = 24;
    localparam int CMD_W = 4;
    localparam int CODE_W = 16;
    localparam int CMD_POS = 20;
    localparam int CODE_POS = 0;
    localparam int SYNC_DEPTH = 2;

    // Reset codes of the two variants
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID = 16'h8000;

    // Command codes
    localparam logic [3:0] CMD_WRITE = 4'h0;
    localparam logic [3:0] CMD_UPDATE = 4'h1;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
    localparam logic [3:0] CMD_NOP = 4'hF;

    // Decoded command
    typedef struct packed {
        logic write;
        logic update;
        logic power_down;
    } sdac_action_t;

    // Link pins after synchronisation
    typedef struct packed {
        logic sclk;
        logic sdata;
        logic select_load_n;
        logic async_update_n;
    } sdac_link_t;

endpackage

/* File: hw/sdac_sync.sv */
/*
 * Two-flop synchroniser for the link pins into the system clock.
 * Assumes pins are asynchronous to clk_i and clear is asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
module sdac_sync
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire sdac_pkg::sdac_link_t pins_i,
    output var sdac_pkg::sdac_link_t sync_o
);

    sdac_pkg::sdac_link_t meta_reg;
    sdac_pkg::sdac_link_t sync_reg;

    // Idle values: clock low, strobe and update high
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_reg <= 4'h3;
            sync_reg <= 4'h3;
        end
        else
        begin
            meta_reg <= pins_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule // sdac_sync
`default_nettype wire

/* File: hw/sdac_core.sv */
/*
 * Control logic of a single-channel serial DAC: shift register, daisy
 * output, command decode, input and DAC registers, power-down state.
 * Assumes the link clock is far slower than clk_i (64 ns vs 5 ns) and
 * that clear and power-on reset both arrive on arst_n_i.
 */
// Function
// RL1 - Sample data in on each serial clock rise while select is low
// RL2 - Frames of 24 or 32 bits are both accepted
// RL3 - Data out shows bit from 32 rises earlier, changing on fall
// RL4 - Data out is always driven, never released
// RL5 - Serial clock ignored while select high; rise of select executes
// RL6 - Clear low resets all registers to zero or midscale code
// RL7 - Update falling with select high copies input to DAC register
// RL8 - Update falling with select low defers copy until select rises
// RL9 - Update pin low powers the DAC up regardless of state
// RL10 - Power-down command ignored while update pin is low
// RL11 - Power-up initialises registers to zero or midscale per variant
// RL12 - Word: command, four spare bits, sixteen data bits, MSB first
// RL13 - Commands: write, update, write and update, power down, no-op
// RL14 - Update copies input to DAC register and powers up
// RL15 - Power-down leaves input and DAC registers unchanged
// RL16 - Decode the last 24 bits shifted, dropping leading spare bits
// RL17 - Output enable inactive in power-down, active on any update
`timescale 1ns/10ps
`default_nettype none
module sdac_core
#(
    parameter bit MIDSCALE = 1'b0
)
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic select_load_n_i,
    input wire logic async_update_n_i,
    output logic sdata_o,
    output logic sdata_oe_o,
    output logic [15:0] dac_code_o,
    output logic [15:0] input_code_o,
    output logic out_enable_o,
    output logic powered_down_o
);

    localparam logic [15:0] RESET_CODE =
        MIDSCALE ? sdac_pkg::CODE_MID : sdac_pkg::CODE_ZERO;

    // Decode a command field into actions
    function automatic sdac_pkg::sdac_action_t decode_cmd(
        input logic [3:0] cmd
    );
        sdac_pkg::sdac_action_t a;
        a = '0;
        unique case (cmd)
            sdac_pkg::CMD_WRITE: a.write = 1'b1;
            sdac_pkg::CMD_UPDATE: a.update = 1'b1;
            sdac_pkg::CMD_WRITE_UPDATE:
            begin
                a.write = 1'b1;
                a.update = 1'b1;
            end
            sdac_pkg::CMD_POWER_DOWN: a.power_down = 1'b1;
            default: a = '0;
        endcase
        return a;
    endfunction

    sdac_pkg::sdac_link_t pins;
    sdac_pkg::sdac_link_t link;
    logic sclk_d_reg;
    logic sel_d_reg;
    logic upd_d_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_rise;
    logic upd_fall;
    logic [31:0] shift_reg;
    logic [15:0] input_reg;
    logic [15:0] dac_reg;
    logic pending_reg;
    logic power_down_reg;
    logic sdata_reg;
    logic oe_reg;
    logic enable_reg;
    logic [3:0] cmd_field;
    logic [15:0] code_field;
    sdac_pkg::sdac_action_t act;
    logic do_write;
    logic do_update;
    logic do_power_down;
    logic [15:0] input_next;

    assign pins.sclk = sclk_i;
    assign pins.sdata = sdata_i;
    assign pins.select_load_n = select_load_n_i;
    assign pins.async_update_n = async_update_n_i;

    // Pin synchronisers
    sdac_sync u_sync
    (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pins_i(pins),
        .sync_o(link)
    );

    // Delayed copies for edge detection
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sclk_d_reg <= 1'b0;
            sel_d_reg <= 1'b1;
            upd_d_reg <= 1'b1;
        end
        else
        begin
            sclk_d_reg <= link.sclk;
            sel_d_reg <= link.select_load_n;
            upd_d_reg <= link.async_update_n;
        end
    end

    // Edge strobes; serial clock rise gated by select, fall not gated
    assign sclk_rise = link.sclk & ~sclk_d_reg & ~link.select_load_n; // RL5
    assign sclk_fall = ~link.sclk & sclk_d_reg;
    assign sel_rise = link.select_load_n & ~sel_d_reg;
    assign upd_fall = ~link.async_update_n & upd_d_reg;

    // Serial shift register, 32 stages
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            shift_reg <= 32'h0000_0000;
        end
        else if (sclk_rise)
        begin
            shift_reg <= {shift_reg[30:0], link.sdata}; // RL1
        end
    end

    // Daisy output retimed on the falling serial clock
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sdata_reg <= 1'b0;
        end
        else if (sclk_fall)
        begin
            sdata_reg <= shift_reg[sdac_pkg::SHIFT_W - 1]; // RL3
        end
    end

    // Data out enable held high from reset
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            oe_reg <= 1'b1;
        end
        else
        begin
            oe_reg <= 1'b1; // RL4
        end
    end

    // Low 24 bits carry the word; any extra leading bits are dropped
    assign cmd_field = shift_reg[sdac_pkg::CMD_POS +: sdac_pkg::CMD_W]; // RL16
    assign code_field =
        shift_reg[sdac_pkg::CODE_POS +: sdac_pkg::CODE_W]; // RL12
    assign act = decode_cmd(cmd_field); // RL13

    // Actions taken on the rise of select; update also on update pin fall with select high
    assign do_write = sel_rise & act.write; // RL2
    assign input_next = do_write ? code_field : input_reg;
    assign do_update = (sel_rise & (act.update | pending_reg // RL8
        | ~link.async_update_n))
        | (upd_fall & link.select_load_n); // RL7
    assign do_power_down = sel_rise & act.power_down
        & link.async_update_n; // RL10

    // Input register
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            input_reg <= RESET_CODE; // RL6 RL11
        end
        else
        begin
            input_reg <= input_next; // RL15
        end
    end

    // DAC register, loaded with the freshest input value
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            dac_reg <= RESET_CODE; // RL6 RL11
        end
        else if (do_update)
        begin
            dac_reg <= input_next; // RL14
        end
    end

    // Deferred update while select is low
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pending_reg <= 1'b0;
        end
        else if (upd_fall & ~link.select_load_n)
        begin
            pending_reg <= 1'b1; // RL8
        end
        else if (sel_rise)
        begin
            pending_reg <= 1'b0;
        end
    end

    // Power-down state
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            power_down_reg <= 1'b0;
        end
        else if (~link.async_update_n | do_update)
        begin
            power_down_reg <= 1'b0; // RL9 RL14
        end
        else if (do_power_down)
        begin
            power_down_reg <= 1'b1; // RL15
        end
    end

    // Output enable follows the power state
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            enable_reg <= 1'b1;
        end
        else if (~link.async_update_n | do_update)
        begin
            enable_reg <= 1'b1; // RL17
        end
        else if (do_power_down)
        begin
            enable_reg <= 1'b0; // RL17
        end
    end

    // Output ports
    assign sdata_o = sdata_reg;
    assign sdata_oe_o = oe_reg;
    assign dac_code_o = dac_reg;
    assign input_code_o = input_reg;
    assign out_enable_o = enable_reg;
    assign powered_down_o = power_down_reg;

endmodule // sdac_core
`default_nettype wire

/* File: verif/sdac_core_sva.sv */
/* Port checker of the serial DAC core.
   Bound to sdac_core; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module sdac_core_sva #(parameter bit MIDSCALE = 1'b0)
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic sclk_i,
    input wire logic select_load_n_i,
    input wire logic async_update_n_i,
    input wire logic sdata_o,
    input wire logic sdata_oe_o,
    input wire logic [15:0] dac_code_o,
    input wire logic [15:0] input_code_o,
    input wire logic powered_down_o
);
    localparam logic [15:0] RST =
        MIDSCALE ? sdac_pkg::CODE_MID : sdac_pkg::CODE_ZERO;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // Update pin falling while deselected
    sequence upd_fall_s;
        $fell(async_update_n_i) && select_load_n_i;
    endsequence
    // Relations between pins and registers
    oe_driven_a: assert property (sdata_oe_o)
        else $error("data out released");
    sdo_on_fall_a: assert property
        ($changed(sdata_o) |-> !$past(sclk_i))
        else $error("data out moved off a fall");
    load_on_select_a: assert property
        ($changed(input_code_o) |-> $past(select_load_n_i))
        else $error("input code moved while selected");
    upd_copy_a: assert property
        (upd_fall_s |-> ##[2:4] dac_code_o == input_code_o)
        else $error("update pin did not copy");
    upd_powerup_a: assert property
        ($fell(async_update_n_i) |-> ##[1:4] !powered_down_o)
        else $error("update pin did not power up");
    pd_blocked_a: assert property
        ($rose(powered_down_o) |-> $past(async_update_n_i, 3))
        else $error("power down with update pin low");
    pd_keeps_codes_a: assert property
        ($rose(powered_down_o) |-> $stable(dac_code_o)
            && $stable(input_code_o))
        else $error("power down moved codes");
    clear_codes_a: assert property (disable iff (1'b0)
        !arst_n_i && $past(!arst_n_i)
            |-> dac_code_o == RST && input_code_o == RST)
        else $error("clear left codes");
endmodule // sdac_core_sva
bind sdac_core sdac_core_sva #(.MIDSCALE(MIDSCALE)) sva_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk_i),
    .select_load_n_i(select_load_n_i),
    .async_update_n_i(async_update_n_i), .sdata_o(sdata_o),
    .sdata_oe_o(sdata_oe_o), .dac_code_o(dac_code_o),
    .input_code_o(input_code_o), .powered_down_o(powered_down_o)
);
`default_nettype wire

/* File: verif/sdac_host.sv */
/* Host model driving the three-wire link, collecting daisy data.
   Link clock 64 ns, low between frames. */
`timescale 1ns/10ps
`default_nettype none
module sdac_host
(
    input wire logic sdo_i,
    output logic sclk_o,
    output logic sdata_o,
    output logic select_load_n_o
);
    logic [31:0] rx_reg;
    // Idle link
    initial
    begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        select_load_n_o = 1'b1;
        rx_reg = 32'h0;
    end
    // One frame, MSB first
    task automatic send(input logic [31:0] w, input int n);
        select_load_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            sdata_o = w[i];
            #32;
            rx_reg = {rx_reg[30:0], sdo_i};
            sclk_o = 1'b1;
            #32;
            sclk_o = 1'b0;
        end
        #20;
        select_load_n_o = 1'b1;
        sdata_o = ~sdata_o; // Released line shows no stale bit
    endtask
    // Serial clock pulses with select high, to be ignored
    task automatic idle_clocks(input int n);
        sdata_o = 1'b1;
        repeat (n)
        begin
            #32;
            sclk_o = 1'b1;
            #32;
            sclk_o = 1'b0;
        end
    endtask
endmodule // sdac_host
`default_nettype wire

/* File: verif/sdac_core_tb_top.sv */
/* Testbench of the serial DAC core with a host model.
   Zero-scale variant, midscale variant for reset codes, 5 ns clock. */
`timescale 1ns/10ps
`default_nettype none
module sdac_core_tb_top;
    typedef struct {
        logic [3:0] c;
        logic [15:0] d;
        int n;
        bit u;
        logic [15:0] ei;
        logic [15:0] ed;
        logic pd;
    } sdac_row_t;
    logic clk_i, arst_n_i, sclk, sdata, sel_n, upd_n, sdo, sdo_oe, oe, pd;
    logic [15:0] dac, inp;
    logic [15:0] mid_dac, mid_inp;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    sdac_row_t rows[10] = '{
        '{4'h0, 16'h1234, 24, 0, 16'h1234, 16'h0000, 1'b0},
        '{4'h1, 16'hFFFF, 32, 0, 16'h1234, 16'h1234, 1'b0},
        '{4'h4, 16'hAAAA, 24, 0, 16'h1234, 16'h1234, 1'b1},
        '{4'hF, 16'h5555, 32, 0, 16'h1234, 16'h1234, 1'b1},
        '{4'hF, 16'h5555, 24, 0, 16'h1234, 16'h1234, 1'b1},
        '{4'h3, 16'hBEEF, 32, 0, 16'hBEEF, 16'hBEEF, 1'b0},
        '{4'h0, 16'h0F0F, 24, 0, 16'h0F0F, 16'hBEEF, 1'b0},
        '{4'h4, 16'h0000, 32, 1, 16'h0F0F, 16'h0F0F, 1'b0},
        '{4'h4, 16'h0000, 24, 0, 16'h0F0F, 16'h0F0F, 1'b1},
        '{4'h0, 16'h1111, 24, 0, 16'h1111, 16'h0F0F, 1'b1}
    };
    sdac_core #(.MIDSCALE(1'b0)) dut_u (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk),
        .sdata_i(sdata), .select_load_n_i(sel_n),
        .async_update_n_i(upd_n), .sdata_o(sdo), .sdata_oe_o(sdo_oe),
        .dac_code_o(dac), .input_code_o(inp), .out_enable_o(oe),
        .powered_down_o(pd)
    );
    // Midscale variant on the same link, reset codes only
    sdac_core #(.MIDSCALE(1'b1)) mid_u (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk),
        .sdata_i(sdata), .select_load_n_i(sel_n),
        .async_update_n_i(upd_n), .sdata_o(), .sdata_oe_o(),
        .dac_code_o(mid_dac), .input_code_o(mid_inp), .out_enable_o(),
        .powered_down_o()
    );
    sdac_host host_u (.sdo_i(sdo), .sclk_o(sclk), .sdata_o(sdata),
        .select_load_n_o(sel_n));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Verdict
    task automatic finish_test();
        if (err_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Wait edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Register and state outputs
    task automatic expect3(input logic [15:0] ei, ed, input logic p);
        check(inp, ei);
        check(dac, ed);
        check(pd, p);
        check(oe, !p);
    endtask
    // System clock
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            finish_test();
        end
    end
    // Main sequence
    initial
    begin
        arst_n_i = 1'b0;
        upd_n = 1'b1;
        tick(16);
        expect3(16'h0000, 16'h0000, 1'b0);
        check(mid_inp, 16'h8000);
        check(mid_dac, 16'h8000);
        arst_n_i = 1'b1;
        tick(4);
        foreach (rows[i])
        begin
            upd_n = !rows[i].u;
            tick(4);
            host_u.send({8'hA5, rows[i].c, 4'hC, rows[i].d}, rows[i].n);
            tick(8);
            upd_n = 1'b1;
            tick(4);
            expect3(rows[i].ei, rows[i].ed, rows[i].pd);
        end
        // Update pin with select high
        upd_n = 1'b0;
        tick(6);
        expect3(16'h1111, 16'h1111, 1'b0);
        upd_n = 1'b1;
        tick(4);
        // Update pulse inside a frame waits for select rise
        fork
            host_u.send({8'h00, 4'h0, 4'h0, 16'h2222}, 32);
            begin
                tick(60);
                upd_n = 1'b0;
                tick(20);
                upd_n = 1'b1;
                tick(20);
                check(dac, 16'h1111);
            end
        join
        tick(6);
        check(dac, 16'h2222);
        // Daisy chain: second frame pushes the first out
        host_u.send(32'hC3F1A55A, 32);
        tick(4);
        host_u.idle_clocks(4);
        tick(4);
        host_u.send(32'h00F00000, 32);
        check(host_u.rx_reg, 32'hC3F1A55A);
        tick(4);
        arst_n_i = 1'b0;
        tick(2);
        expect3(16'h0000, 16'h0000, 1'b0);
        check(sdo_oe, 1'b1);
        check(sdo, 1'b0);
        check(mid_inp, 16'h8000);
        check(mid_dac, 16'h8000);
        arst_n_i = 1'b1;
        tick(4);
        expect3(16'h0000, 16'h0000, 1'b0);
        finish_test();
    end
endmodule // sdac_core_tb_top
`default_nettype wire
